// ===== include/sram_pkg.sv
/*
  constants, field layouts and operation codes of the flow-through
  burst sram block and its wishbone register window.
  assumes nothing of its surroundings.
*/
package sram_pkg;

  // -------------------------------------------------------------------
  // organisations
  // -------------------------------------------------------------------
  localparam int ORG_X72   = 0;
  localparam int ORG_X36   = 1;
  localparam int ORG_X18   = 2;
  localparam int LANES_X72 = 8;
  localparam int LANES_X36 = 4;
  localparam int LANES_X18 = 2;
  localparam int AW_X72    = 18;
  localparam int AW_X36    = 19;
  localparam int AW_X18    = 20;
  localparam int DATA_W    = 8;
  localparam int LANE_W    = 9;
  localparam int BURST_W   = 2;

  // -------------------------------------------------------------------
  // register window
  // -------------------------------------------------------------------
  localparam int          WB_AW          = 4;
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_WCOUNT     = 4'h8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int          CTRL_WPROT     = 0;
  localparam int          CTRL_WIDTH     = 1;
  localparam int          STAT_OP_LSB    = 0;
  localparam int          STAT_LOW_LSB   = 4;
  localparam int          STAT_BEAT_LSB  = 6;
  localparam int          STAT_SUSPEND   = 8;
  localparam int          STAT_SLEEP     = 9;
  localparam int          STAT_MODE      = 10;
  localparam int          WCOUNT_W       = 16;
  localparam logic [15:0] WCOUNT_RESET   = 16'h0000;

  // -------------------------------------------------------------------
  // operation state
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b100
  } op_e;

endpackage

// ===== hdl/burst_seq.sv
/*
  two-bit burst address sequencer: seeds from the low address bits,
  steps linear or interleaved.
  assumes one clock, a synchronous active-high reset and a hold input
  that freezes it.
*/
`timescale 1ns/10ps
module burst_seq (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       hold_i,
  input  wire logic       load_i,
  input  wire logic       step_i,
  input  wire logic [1:0] seed_i,
  input  wire logic       interleave_i,
  output logic      [1:0] burst_low_o,
  output logic      [1:0] next_low_o,
  output logic      [1:0] beat_o
);

  logic [1:0] seed;
  logic [1:0] next_seed;
  logic [1:0] next_beat;

  // -------------------------------------------------------------------
  // next address
  // -------------------------------------------------------------------
  always_comb begin
    next_seed = seed;
    next_beat = beat_o;
    if (load_i) begin
      next_seed = seed_i;
      next_beat = 2'h0;
    end else if (step_i) begin
      next_beat = beat_o + 2'h1;
    end
    if (interleave_i) begin
      next_low_o = next_seed ^ next_beat;
    end else begin
      next_low_o = next_seed + next_beat;
    end
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seed        <= 2'h0;
      beat_o      <= 2'h0;
      burst_low_o <= 2'h0;
    end else if (!hold_i) begin
      seed        <= next_seed;
      beat_o      <= next_beat;
      burst_low_o <= next_low_o;
    end
  end

endmodule

// ===== hdl/nowait_sram.sv
/*
  flow-through no-wait-state burst sram: synchronous pin interface,
  flip-flop array, burst sequencing and a wishbone register window.
  assumes host pins are driven from logic on clk_i; the burst-order and
  sleep pins are static straps and are synchronised here.
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
// Notes on behaviour
// - all bus inputs except output enable taken on rising clk edge
// - clock gate high freezes every sram state; strap synchronisers and register window keep running
// - step/load low loads a new address
// - step/load high advances the burst counter unless the last load deselected the device
// - burst counter is two bits wide
// - write requested by low write control
// - only strobed byte lanes are written
// - burst order pin: high interleaved, low linear
// - reads and writes run back to back
// - selected only when all three enables active
// - organisation x72, x36 or x18 by parameter
`timescale 1ns/10ps
module nowait_sram #(
  parameter int ORG   = sram_pkg::ORG_X36,
  parameter int LANES = (ORG == sram_pkg::ORG_X72) ? sram_pkg::LANES_X72 :
                        (ORG == sram_pkg::ORG_X36) ? sram_pkg::LANES_X36 :
                                                     sram_pkg::LANES_X18,
  parameter int AW    = (ORG == sram_pkg::ORG_X72) ? sram_pkg::AW_X72 :
                        (ORG == sram_pkg::ORG_X36) ? sram_pkg::AW_X36 :
                                                     sram_pkg::AW_X18
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // sram pins
  input  wire logic                       clk_gate_n_i,
  input  wire logic                       burst_step_or_load_i,
  input  wire logic [AW-1:0]              addr_i,
  input  wire logic                       write_n_i,
  input  wire logic [LANES-1:0]           byte_lane_write_n_i,
  input  wire logic                       chip_select_n_i,
  input  wire logic                       chip_select_secondary_i,
  input  wire logic                       chip_select_secondary_n_i,
  input  wire logic                       output_enable_n_i,
  input  wire logic                       burst_order_i,
  input  wire logic                       sleep_request_i,
  input  wire logic [LANES*8-1:0]         data_lane_i,
  output logic      [LANES*8-1:0]         data_lane_o,
  output logic      [LANES*8-1:0]         data_lane_oe_o,
  input  wire logic [LANES-1:0]           parity_lane_i,
  output logic      [LANES-1:0]           parity_lane_o,
  output logic      [LANES-1:0]           parity_lane_oe_o,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [sram_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o
);

  localparam int WORD_W = LANES * sram_pkg::LANE_W;

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  logic [WORD_W-1:0]          mem [2**AW];
  logic [1:0]                 mode_sync;
  logic [1:0]                 sleep_sync;
  logic                       interleave;
  logic                       sleeping;
  logic                       hold;
  logic                       selected;
  logic                       load;
  sram_pkg::op_e              op;
  sram_pkg::op_e              next_op;
  logic [AW-3:0]              addr_hi;
  logic [AW-3:0]              next_addr_hi;
  logic [1:0]                 burst_low;
  logic [1:0]                 next_low;
  logic [1:0]                 beat;
  logic [AW-1:0]              cur_addr;
  logic [AW-1:0]              next_addr;
  logic [LANES-1:0]           lane_en;
  logic [WORD_W-1:0]          wr_word;
  logic [WORD_W-1:0]          rd_raw;
  logic [WORD_W-1:0]          rd_word;
  logic                       commit;
  logic                       bypass;
  logic [WORD_W-1:0]          rd_data_q;
  logic [sram_pkg::CTRL_WIDTH-1:0] ctrl;
  logic                       wprot;
  logic [sram_pkg::WCOUNT_W-1:0]   wcount;
  logic                       wb_req;
  logic [31:0]                status;
  logic [31:0]                next_wb_dat;

  // -------------------------------------------------------------------
  // strap synchronisers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_sync  <= 2'h0;
      sleep_sync <= 2'h0;
    end else begin
      mode_sync  <= {mode_sync[0], burst_order_i};
      sleep_sync <= {sleep_sync[0], sleep_request_i};
    end
  end

  assign interleave = mode_sync[1];
  assign sleeping   = sleep_sync[1];

  // -------------------------------------------------------------------
  // cycle decode
  // -------------------------------------------------------------------
  assign hold     = clk_gate_n_i | sleeping;
  assign selected = ~chip_select_n_i & chip_select_secondary_i
                  & ~chip_select_secondary_n_i;
  assign load     = ~burst_step_or_load_i;

  always_comb begin
    next_op      = op;
    next_addr_hi = addr_hi;
    if (load) begin
      next_addr_hi = addr_i[AW-1:2];
      if (!selected) begin
        next_op = sram_pkg::OP_IDLE;
      end else if (!write_n_i) begin
        next_op = sram_pkg::OP_WRITE;
      end else begin
        next_op = sram_pkg::OP_READ;
      end
    end
  end

  burst_seq u_burst_seq (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .hold_i       (hold),
    .load_i       (load),
    .step_i       (op != sram_pkg::OP_IDLE),
    .seed_i       (addr_i[1:0]),
    .interleave_i (interleave),
    .burst_low_o  (burst_low),
    .next_low_o   (next_low),
    .beat_o       (beat)
  );

  assign cur_addr  = {addr_hi, burst_low};
  assign next_addr = {next_addr_hi, next_low};

  // -------------------------------------------------------------------
  // operation state and byte strobes
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op      <= sram_pkg::OP_IDLE;
      addr_hi <= '0;
      lane_en <= '0;
    end else if (!hold) begin
      op      <= next_op;
      addr_hi <= next_addr_hi;
      lane_en <= ~byte_lane_write_n_i;
    end
  end

  // -------------------------------------------------------------------
  // array write: data follows its address by one clock
  // -------------------------------------------------------------------
  assign commit = ~hold & (op == sram_pkg::OP_WRITE) & ~wprot;

  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      localparam int B = l * sram_pkg::LANE_W;
      assign wr_word[B +: sram_pkg::LANE_W] = lane_en[l] ?
        {parity_lane_i[l], data_lane_i[l*8 +: 8]} :
        mem[cur_addr][B +: sram_pkg::LANE_W];
      assign rd_word[B +: sram_pkg::LANE_W] = (bypass && lane_en[l]) ?
        wr_word[B +: sram_pkg::LANE_W] : rd_raw[B +: sram_pkg::LANE_W];
      assign data_lane_o[l*sram_pkg::DATA_W +: sram_pkg::DATA_W] =
        rd_data_q[B +: sram_pkg::DATA_W];
      assign parity_lane_o[l] = rd_data_q[B + sram_pkg::DATA_W];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (commit) begin
      mem[cur_addr] <= wr_word;
    end
  end

  // -------------------------------------------------------------------
  // flow-through read: word registered on the capture edge
  // -------------------------------------------------------------------
  assign rd_raw = mem[next_addr];
  assign bypass = commit & (cur_addr == next_addr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= '0;
    end else if (!hold && next_op == sram_pkg::OP_READ) begin
      rd_data_q <= rd_word;
    end
  end

  // drivers stay off during write and deselect so the bus can turn round
  always_comb begin
    data_lane_oe_o   = '0;
    parity_lane_oe_o = '0;
    if (op == sram_pkg::OP_READ && !output_enable_n_i && !sleeping) begin
      data_lane_oe_o   = '1;
      parity_lane_oe_o = '1;
    end
  end

  // -------------------------------------------------------------------
  // write counter
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcount <= sram_pkg::WCOUNT_RESET;
    end else if (commit) begin
      wcount <= wcount + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // wishbone register window
  // -------------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wprot  = ctrl[sram_pkg::CTRL_WPROT];

  always_comb begin
    status = 32'h0000_0000;
    status[sram_pkg::STAT_OP_LSB +: 3]  = op;
    status[sram_pkg::STAT_LOW_LSB +: 2] = burst_low;
    status[sram_pkg::STAT_BEAT_LSB +: 2] = beat;
    status[sram_pkg::STAT_SUSPEND]      = clk_gate_n_i;
    status[sram_pkg::STAT_SLEEP]        = sleeping;
    status[sram_pkg::STAT_MODE]         = interleave;
  end

  always_comb begin
    case (wb_adr_i)
      sram_pkg::REG_CTRL: begin
        next_wb_dat = {31'h0000_0000, ctrl};
      end
      sram_pkg::REG_STATUS: begin
        next_wb_dat = status;
      end
      sram_pkg::REG_WCOUNT: begin
        next_wb_dat = {16'h0000, wcount};
      end
      default: begin
        next_wb_dat = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? next_wb_dat : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= sram_pkg::CTRL_RESET[sram_pkg::CTRL_WIDTH-1:0];
    end else if (wb_req && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == sram_pkg::REG_CTRL) begin
      ctrl <= wb_dat_i[sram_pkg::CTRL_WIDTH-1:0];
    end
  end

endmodule

// ===== verification/nowait_sram_properties.sv
/* timing checks on the sram pins and register bus of nowait_sram.
   bound to nowait_sram and sees its ports only. */
`timescale 1ns/10ps
module nowait_sram_properties #(
  parameter int LANES = 4
) (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       clk_gate_n_i,
  input wire logic                       burst_step_or_load_i,
  input wire logic                       write_n_i,
  input wire logic                       chip_select_n_i,
  input wire logic                       chip_select_secondary_i,
  input wire logic                       chip_select_secondary_n_i,
  input wire logic                       output_enable_n_i,
  input wire logic                       sleep_request_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [sram_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic [LANES*8-1:0]         data_lane_o,
  input wire logic [LANES*8-1:0]         data_lane_oe_o,
  input wire logic [LANES-1:0]           parity_lane_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic en, sel, req, ld;
  assign en  = !clk_gate_n_i && !sleep_request_i;
  assign sel = !chip_select_n_i && chip_select_secondary_i &&
               !chip_select_secondary_n_i;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ld  = en && !burst_step_or_load_i;
  sequence s_rd_load;
    ld && sel && write_n_i && !output_enable_n_i;
  endsequence
  sequence s_step;
    en && burst_step_or_load_i && !output_enable_n_i;
  endsequence
  a_read_drives: assert property (s_rd_load |=> &data_lane_oe_o)
    else $error("read load not followed by driven bus");
  a_burst_drives: assert property (
    s_rd_load ##1 s_step |=> &data_lane_oe_o)
    else $error("burst step dropped the read");
  a_write_quiet: assert property (
    ld && sel && !write_n_i |=> data_lane_oe_o == '0)
    else $error("bus driven in write data cycle");
  a_desel_quiet: assert property (
    ld && !sel |=> data_lane_oe_o == '0)
    else $error("bus driven after deselect");
  a_gate_holds: assert property (
    clk_gate_n_i |=> $stable(data_lane_o))
    else $error("output moved on suspended edge");
  a_parity_pair: assert property (
    (|data_lane_oe_o) == (|parity_lane_oe_o))
    else $error("parity drive differs from data drive");
  a_ack_time: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (
    req && !wb_we_i && wb_adr_i[3:2] == 2'b11 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind nowait_sram nowait_sram_properties #(.LANES(LANES))
  nowait_sram_properties_inst (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .clk_gate_n_i              (clk_gate_n_i),
    .burst_step_or_load_i      (burst_step_or_load_i),
    .write_n_i                 (write_n_i),
    .chip_select_n_i           (chip_select_n_i),
    .chip_select_secondary_i   (chip_select_secondary_i),
    .chip_select_secondary_n_i (chip_select_secondary_n_i),
    .output_enable_n_i         (output_enable_n_i),
    .sleep_request_i           (sleep_request_i),
    .wb_cyc_i                  (wb_cyc_i),
    .wb_stb_i                  (wb_stb_i),
    .wb_we_i                   (wb_we_i),
    .wb_adr_i                  (wb_adr_i),
    .wb_dat_o                  (wb_dat_o),
    .wb_ack_o                  (wb_ack_o),
    .data_lane_o               (data_lane_o),
    .data_lane_oe_o            (data_lane_oe_o),
    .parity_lane_oe_o          (parity_lane_oe_o)
  );

// ===== verification/host_model.sv
/* host controller model for the x36 sram pins.
   assumes the bench calls beat() once per clock cycle. */
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic [35:0] dev_q_i,
  input  wire logic [35:0] dev_oe_i,
  output logic             gate_n_o,
  output logic             step_o,
  output logic [18:0]      addr_o,
  output logic             write_n_o,
  output logic [3:0]       be_n_o,
  output logic [2:0]       cs_o,
  output logic [35:0]      bus_o,
  output logic             cap_o
);
  logic        hdrv, pw, cw, cur_rd;
  logic [35:0] hd, pd;
  // released lines show the inverse of the host's current data word hd
  assign bus_o = (dev_oe_i & dev_q_i) | (~dev_oe_i & (hdrv ? hd : ~hd));
  wire rd_now = step_o ? cur_rd : (cs_o == 3'b010 && write_n_o);
  initial begin
    {gate_n_o, step_o, write_n_o, hdrv, pw, cw, cur_rd, cap_o} = 8'h80;
    addr_o = '0;
    be_n_o = 4'hf;
    cs_o = 3'b101;
    hd = '0;
    pd = '0;
  end
  // cap_o marks the cycle that carries read data
  always @(posedge clk_i) begin
    if (!gate_n_o) cur_rd <= rd_now;
    cap_o <= !gate_n_o && rd_now;
  end
  // --------------------------------------------------------------
  // one pin cycle
  // --------------------------------------------------------------
  task automatic beat(input logic ld, wr, input logic [18:0] a,
                      input logic [3:0] ben, input logic [35:0] wd,
                      input int sel, input logic gate);
    @(posedge clk_i);
    gate_n_o  <= gate;
    step_o    <= !ld;
    addr_o    <= a;
    write_n_o <= !wr;
    be_n_o    <= ben;
    cs_o      <= sel == 0 ? 3'b010 : 3'b010 ^ 3'(4 >> (sel - 1));
    if (!gate) begin
      hdrv <= pw;
      hd   <= pd;
      if (ld) cw = sel == 0 && wr;
      pw = cw;
      pd = wd;
    end
  endtask
endmodule

// ===== verification/testbench.sv
/* self-checking bench for nowait_sram in its default x36 form.
   assumes host_model and the bound checker are compiled with it. */
`timescale 1ns/10ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        mode = 1'b0;
  logic [31:0] q, qoe, wdat, rdat;
  logic [35:0] bus, ref_mem [16];
  logic [3:0]  p, poe, be_n, adr;
  logic [18:0] addr;
  logic [14:0] base;
  logic [2:0]  cs;
  logic        gate_n, step, wr_n, cap, ack, cyc, stb, we, wprot;
  logic [63:0] e, exp_q [$], wb_q [$];
  int          n_mismatch, num_checks, nwr, cycles;
  nowait_sram nowait_sram_inst (.clk_i, .rst_i, .clk_gate_n_i(gate_n),
    .burst_step_or_load_i(step), .addr_i(addr), .write_n_i(wr_n),
    .byte_lane_write_n_i(be_n), .chip_select_n_i(cs[2]),
    .chip_select_secondary_i(cs[1]), .chip_select_secondary_n_i(cs[0]),
    .output_enable_n_i(1'b0), .burst_order_i(mode),
    .sleep_request_i(1'b0), .data_lane_i(bus[31:0]), .data_lane_o(q),
    .data_lane_oe_o(qoe), .parity_lane_i(bus[35:32]), .parity_lane_o(p),
    .parity_lane_oe_o(poe), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  host_model host_model_inst (.clk_i, .dev_q_i({p, q}),
    .dev_oe_i({poe, qoe}), .gate_n_o(gate_n), .step_o(step),
    .addr_o(addr), .write_n_o(wr_n), .be_n_o(be_n), .cs_o(cs),
    .bus_o(bus), .cap_o(cap));
  initial forever #12.5 clk_i = ~clk_i;
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, m);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    if (!w) wb_q.push_back({m, d});
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic idle;
    host_model_inst.beat(1, 0, '0, 4'hf, '0, 1, 0);
  endtask
  task automatic burst(input logic wr, input logic [3:0] a, ben,
                       input logic susp);
    logic [3:0]  x;
    logic [35:0] wd;
    for (int k = 0; k < 4; k++) begin
      x = {a[3:2], mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
      wd = 36'({$urandom, $urandom});
      if (susp && k == 2) host_model_inst.beat(1, 1, '0, 4'h0, '1, 0, 1);
      host_model_inst.beat(k == 0, wr, {base, x}, ben, wd, 0, 0);
      if (!wr) exp_q.push_back({28'h0, ref_mem[x]});
      else if (!wprot) begin
        nwr++;
        for (int i = 0; i < 4; i++) begin
          if (!ben[i]) {ref_mem[x][32+i], ref_mem[x][8*i+:8]} =
            {wd[32+i], wd[8*i+:8]};
        end
      end
    end
  endtask
  // --------------------------------------------------------------
  // monitors and main sequence
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (cap === 1'b1) check({28'h0, p, q},
      exp_q.size() > 0 ? exp_q.pop_front() : {64{1'b1}});
    if (ack === 1'b1 && we === 1'b0 && wb_q.size() > 0) begin
      e = wb_q.pop_front();
      check({32'h0, rdat & e[63:32]}, {32'h0, e[31:0]});
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    {cyc, stb, we, adr, wdat, wprot} = '0;
    void'($urandom(32'hf6f8607c));
    base = 15'($urandom);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(0, 4'h0, 32'h0, '1);
    wb(0, 4'h8, 32'h0, 32'hffff);
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      repeat (3) @(posedge clk_i);
      wb(0, 4'h4, {21'h0, m[0], 10'h0}, 32'h400);
      for (int g = 0; g < 16; g += 4) burst(1, 4'(g), 4'h0, 0);
      for (int j = 0; j < 12; j++) begin
        burst(j[0], 4'($urandom), 4'($urandom) & 4'h7, j[2]);
      end
      idle;
    end
    for (int s = 1; s < 4; s++) begin
      host_model_inst.beat(1, 0, '0, 4'h0, '0, s, 0);
      host_model_inst.beat(0, 0, '0, 4'h0, '0, 0, 0);
    end
    wb(1, 4'h0, 32'h1, '0);
    wprot = 1'b1;
    burst(1, 4'h3, 4'h0, 0);
    burst(0, 4'h3, 4'h0, 0);
    idle;
    wb(1, 4'hc, 32'hffff_ffff, '0);
    wb(0, 4'hc, 32'h0, '1);
    wb(0, 4'h0, 32'h1, '1);
    wb(0, 4'h8, 32'(nwr), 32'hffff);
    repeat (4) @(posedge clk_i);
    check(64'(exp_q.size() + wb_q.size()), 64'h0);
    give_verdict;
  end
endmodule
